// file: include/asf_pkg.sv
// shared constants of the converter status flag block
package asf_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] ASF_OFF_STATUS   = 5'h00;
  localparam logic [4:0] ASF_OFF_IFMODE   = 5'h04;
  localparam logic [4:0] ASF_OFF_DATA     = 5'h08;
  localparam logic [4:0] ASF_OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] ASF_OFF_IRQ_MASK = 5'h10;
  localparam int          ASF_ADDR_W       = 5;

  // status field positions
  localparam int ASF_BIT_RDY     = 7;
  localparam int ASF_BIT_ADC_ERR = 6;
  localparam int ASF_BIT_CRC_ERR = 5;
  localparam int ASF_BIT_REG_ERR = 4;
  localparam int ASF_BIT_RSVD    = 3;

  // interface mode field positions
  localparam int ASF_BIT_APPEND    = 0;
  localparam int ASF_BIT_REG_CHECK = 1;

  // reset values
  localparam logic [7:0]  ASF_STATUS_RST = 8'h80;
  localparam logic [7:0]  ASF_IFMODE_RST = 8'h00;
  localparam logic [7:0]  ASF_MASK_RST   = 8'h00;
  localparam logic [23:0] ASF_DATA_RST   = 24'h000000;

  // clamp values of the result
  localparam logic [23:0] ASF_CLAMP_HI = 24'hffffff;
  localparam logic [23:0] ASF_CLAMP_LO = 24'h000000;

  localparam int ASF_DATA_W = 24;
  localparam int ASF_SIG_W  = 16;
  localparam int ASF_SYNC_N = 3;
endpackage : asf_pkg

// file: logic/asf_status_flags.sv
// converter status flags with avalon slave, ready pin driver and interrupt
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module asf_status_flags
  import asf_pkg::*;
#(
  parameter int IMAGE_W = 64
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // avalon-mm slave
  input  wire logic [ASF_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       irq,
  // conversion path and calibration sequencer
  input  wire logic                  result_valid,
  input  wire logic [23:0]           result_data,
  input  wire logic                  result_over,
  input  wire logic                  result_under,
  input  wire logic                  cal_mode,
  input  wire logic                  cal_done,
  // serial framing on the same clock
  input  wire logic                  crc_write_fail,
  input  wire logic                  ser_data_read,
  input  wire logic                  ser_status_read,
  input  wire logic                  reg_read_active,
  // image of the protected registers
  input  wire logic [IMAGE_W-1:0]    reg_image,
  // pins
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  output logic                       dout_rdy_o,
  output logic                       dout_rdy_oe,
  // data readout with optional appended status
  output logic      [31:0]           readout_word,
  output logic                       readout_with_status
);

  initial begin
    if (IMAGE_W < ASF_SIG_W) begin
      $error("IMAGE_W must be at least ASF_SIG_W");
    end
    if (ASF_SYNC_N < 2) begin
      $error("ASF_SYNC_N must be at least 2");
    end
    if (ASF_DATA_W != 24) begin
      $error("ASF_DATA_W must match the 24 bit result");
    end
  end

  typedef struct packed {
    // pin synchronisers
    logic [ASF_SYNC_N-1:0] cs_sync;
    logic [ASF_SYNC_N-1:0] sclk_sync;
    // status flags
    logic                  rdy;
    logic                  adc_err;
    logic                  crc_err;
    logic                  reg_err;
    // mode and integrity reference
    logic [7:0]            ifmode;
    logic [ASF_SIG_W-1:0]  ref_sig;
    logic [23:0]           data;
    // interrupt
    logic [7:0]            irq_stat;
    logic [7:0]            irq_mask;
    // bus side
    logic [7:0]            shift;
    logic                  wait_n;
    logic                  waitreq;
    logic [31:0]           rdata;
    // pin and readout outputs
    logic                  irq;
    logic                  dout;
    logic                  dout_oe;
    logic [31:0]           readout;
    logic                  with_stat;
  } asf_state_t;

  // synchronisers start at the idle pin levels so reset gives no false edge
  localparam asf_state_t ASF_STATE_RST = '{
    cs_sync:   '1,
    sclk_sync: '1,
    rdy:       ASF_STATUS_RST[ASF_BIT_RDY],
    adc_err:   ASF_STATUS_RST[ASF_BIT_ADC_ERR],
    crc_err:   ASF_STATUS_RST[ASF_BIT_CRC_ERR],
    reg_err:   ASF_STATUS_RST[ASF_BIT_REG_ERR],
    ifmode:    ASF_IFMODE_RST,
    ref_sig:   '0,
    data:      ASF_DATA_RST,
    irq_stat:  8'h00,
    irq_mask:  ASF_MASK_RST,
    shift:     8'h00,
    wait_n:    1'b0,
    waitreq:   1'b1,
    rdata:     32'h00000000,
    irq:       1'b0,
    dout:      1'b1,
    dout_oe:   1'b0,
    readout:   32'h00000000,
    with_stat: 1'b0
  };

  // xor fold of the register image into a short signature
  // a short fold keeps the compare small; two flipped bits in one lane cancel
  function automatic logic [ASF_SIG_W-1:0] asf_fold(input logic [IMAGE_W-1:0] img);
    logic [ASF_SIG_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < IMAGE_W; i++) begin
      acc[i % ASF_SIG_W] = acc[i % ASF_SIG_W] ^ img[i];
    end
    return acc;
  endfunction : asf_fold

  // reset enters asynchronously, leaves two edges later on the clock
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  asf_state_t s_q;
  asf_state_t s_d;

  logic       acc_new;
  logic       rd_hit;
  logic       wr_hit;
  logic       wr_ifmode;
  logic       wr_mask;
  logic       rd_status;
  logic       rd_data;
  logic       rd_irq;
  logic       result_wr;
  logic       conv_wr;
  logic       sclk_fall;
  logic       selected;
  logic       chk_on_new;
  logic [7:0] status_byte;
  logic [7:0] events;
  logic [23:0] clamped;
  logic [31:0] rd_mux;

  always_comb begin
    s_d = s_q;

    // pins pass three flops; only the later stages are looked at
    // the third stage only feeds the serial clock edge detector
    s_d.cs_sync   = {s_q.cs_sync[ASF_SYNC_N-2:0], cs_n};
    s_d.sclk_sync = {s_q.sclk_sync[ASF_SYNC_N-2:0], sclk};
    selected  = !s_q.cs_sync[ASF_SYNC_N-2];
    sclk_fall = s_q.sclk_sync[ASF_SYNC_N-1] && !s_q.sclk_sync[ASF_SYNC_N-2];

    // one wait cycle, then the answer; wait_n high marks the answer cycle
    acc_new   = (avs_read || avs_write) && !s_q.wait_n;
    rd_hit    = acc_new && avs_read;
    wr_hit    = acc_new && avs_write;
    rd_status = rd_hit && (avs_address == ASF_OFF_STATUS);
    rd_data   = rd_hit && (avs_address == ASF_OFF_DATA);
    rd_irq    = rd_hit && (avs_address == ASF_OFF_IRQ_STAT);
    // write decode
    wr_ifmode = wr_hit && (avs_address == ASF_OFF_IFMODE);
    wr_mask   = wr_hit && (avs_address == ASF_OFF_IRQ_MASK);
    // one flop per stage keeps the bus answer fixed at one wait cycle
    s_d.wait_n  = acc_new;
    s_d.waitreq = !acc_new;

    // channel bits are out of scope and read zero
    status_byte = 8'h00;
    status_byte[2:0] = 3'h0;
    status_byte[ASF_BIT_RDY]     = s_q.rdy;
    status_byte[ASF_BIT_ADC_ERR] = s_q.adc_err;
    status_byte[ASF_BIT_CRC_ERR] = s_q.crc_err;
    status_byte[ASF_BIT_REG_ERR] = s_q.reg_err;
    status_byte[ASF_BIT_RSVD]    = 1'b0;

    // conversion and calibration results
    conv_wr   = result_valid && !cal_mode;
    result_wr = conv_wr || (cal_mode && cal_done);
    // over wins over under when both are flagged
    if (result_over) begin
      clamped = ASF_CLAMP_HI;
    end else if (result_under) begin
      clamped = ASF_CLAMP_LO;
    end else begin
      clamped = result_data;
    end
    if (conv_wr) begin
      s_d.data    = clamped;
      s_d.adc_err = result_over || result_under;
    end

    // a new result beats a concurrent data read: the host has not seen it yet
    if (result_wr) begin
      s_d.rdy = 1'b0;
    end else if (rd_data || ser_data_read) begin
      s_d.rdy = 1'b1;
    end

    // set wins over the read clear so no failed write goes unseen
    if (crc_write_fail) begin
      s_d.crc_err = 1'b1;
    end else if (rd_status || ser_status_read) begin
      s_d.crc_err = 1'b0;
    end

    // interface mode writes; reserved mode bits stay zero
    chk_on_new = s_q.ifmode[ASF_BIT_REG_CHECK];
    if (wr_ifmode) begin
      s_d.ifmode = 8'h00;
      s_d.ifmode[ASF_BIT_APPEND]    = avs_writedata[ASF_BIT_APPEND];
      s_d.ifmode[ASF_BIT_REG_CHECK] = avs_writedata[ASF_BIT_REG_CHECK];
      chk_on_new = avs_writedata[ASF_BIT_REG_CHECK];
    end
    // the reserved bit can never raise the line
    if (wr_mask) begin
      s_d.irq_mask = avs_writedata[7:0];
      s_d.irq_mask[ASF_BIT_RSVD] = 1'b0;
    end

    // integrity check; the reference is taken as the enable rises
    // compare starts the cycle after capture so a fresh reference never trips
    if (chk_on_new && !s_q.ifmode[ASF_BIT_REG_CHECK]) begin
      s_d.ref_sig = asf_fold(reg_image);
    end
    if (!chk_on_new) begin
      s_d.reg_err = 1'b0;
    end else if (s_q.ifmode[ASF_BIT_REG_CHECK] && asf_fold(reg_image) != s_q.ref_sig) begin
      s_d.reg_err = 1'b1;
    end

    // interrupt events share the status layout
    events = 8'h00;
    events[ASF_BIT_RDY]     = result_wr;
    events[ASF_BIT_ADC_ERR] = conv_wr && (result_over || result_under);
    events[ASF_BIT_CRC_ERR] = crc_write_fail;
    events[ASF_BIT_REG_ERR] = s_d.reg_err && !s_q.reg_err;
    // an integrity interrupt fires once, on the rising flag
    // clear then set so an event in the read cycle is kept
    if (rd_irq) begin
      s_d.irq_stat = events;
    end else begin
      s_d.irq_stat = s_q.irq_stat | events;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // read data mux; unmapped offsets read zero
    case (avs_address)
      ASF_OFF_STATUS: begin
        rd_mux = {24'h000000, status_byte};
      end
      ASF_OFF_IFMODE: begin
        rd_mux = {24'h000000, s_q.ifmode};
      end
      ASF_OFF_DATA: begin
        rd_mux = {8'h00, s_q.data};
      end
      ASF_OFF_IRQ_STAT: begin
        rd_mux = {24'h000000, s_q.irq_stat};
      end
      ASF_OFF_IRQ_MASK: begin
        rd_mux = {24'h000000, s_q.irq_mask};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
    // read data is captured once, at the accept edge
    if (rd_hit) begin
      s_d.rdata = rd_mux;
    end

    // data readout word with the status byte appended behind it
    if (rd_data || ser_data_read) begin
      if (s_q.ifmode[ASF_BIT_APPEND]) begin
        s_d.readout   = {s_q.data, status_byte};
        s_d.with_stat = 1'b1;
      end else begin
        s_d.readout   = {8'h00, s_q.data};
        s_d.with_stat = 1'b0;
      end
    end

    // status byte shifts out on sclk falls during a status read frame
    // a trailing fall after the last bit only shifts in zeros
    if (ser_status_read) begin
      s_d.shift = status_byte;
    end else if (reg_read_active && sclk_fall) begin
      s_d.shift = {s_q.shift[6:0], 1'b0};
    end

    // pin shows ready whenever selected and no register read runs
    // oe follows the synchronised select, so it lags the pin by three edges
    s_d.dout_oe = selected;
    if (reg_read_active) begin
      s_d.dout = s_d.shift[7];
    end else begin
      s_d.dout = s_d.rdy;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ASF_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a register field
  assign avs_readdata        = s_q.rdata;
  assign avs_waitrequest     = s_q.waitreq;
  assign irq                 = s_q.irq;
  assign dout_rdy_o          = s_q.dout;
  assign dout_rdy_oe         = s_q.dout_oe;
  assign readout_word        = s_q.readout;
  assign readout_with_status = s_q.with_stat;

endmodule : asf_status_flags

// file: testbench/asf_host_model.sv
// host side model driving chip select and the serial clock
`timescale 1ns/100ps
module asf_host_model (
  input  wire logic mclk,
  input  wire logic dout_rdy_o,
  output logic      cs_n,
  output logic      sclk,
  output logic      reg_read_active,
  output logic      ser_status_read
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    reg_read_active = 1'b0;
    ser_status_read = 1'b0;
  end
  task automatic sel(input logic on);
    @(posedge mclk) cs_n <= !on;
    repeat (4) @(posedge mclk);
  endtask : sel
  // serial clock stands high outside frames; 160 ns period inside
  task automatic rd_status(output logic [7:0] b);
    @(posedge mclk) ser_status_read <= 1'b1;
    reg_read_active <= 1'b1;
    @(posedge mclk) ser_status_read <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge mclk);
      b = {b[6:0], dout_rdy_o};
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
    end
    reg_read_active <= 1'b0;
  endtask : rd_status
endmodule : asf_host_model

// file: testbench/asf_monitor.sv
// assertion checker of the status flag block ports
`timescale 1ns/100ps
module asf_monitor
  import asf_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        result_valid,
  input wire logic        cal_mode,
  input wire logic        cal_done,
  input wire logic        ser_data_read,
  input wire logic        reg_read_active,
  input wire logic        cs_n,
  input wire logic        dout_rdy_o,
  input wire logic        dout_rdy_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire on_pin = dout_rdy_oe && !reg_read_active;
  rdy_drop_a: assert property (result_valid && !cal_mode ##1 on_pin |-> !dout_rdy_o)
    else $error("ready pin not low after result");
  cal_drop_a: assert property (cal_mode && cal_done ##1 on_pin |-> !dout_rdy_o)
    else $error("ready pin not low after calibration");
  rdy_back_a: assert property (ser_data_read && !result_valid && !cal_done ##1 on_pin |-> dout_rdy_o)
    else $error("ready pin not high after data read");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_end_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  oe_rise_a: assert property ($fell(cs_n) ##1 !cs_n [*3] |-> dout_rdy_oe)
    else $error("pin not driven while selected");
  oe_drop_a: assert property ($rose(cs_n) ##1 cs_n [*3] |-> !dout_rdy_oe)
    else $error("pin driven while deselected");
  rsvd_zero_a: assert property (avs_read && avs_waitrequest && avs_address == ASF_OFF_STATUS
    |=> avs_readdata[3:0] == 4'h0)
    else $error("reserved status bit not zero");
  rst_rdy_a: assert property ($rose(resetn) |-> dout_rdy_o)
    else $error("ready not high at reset");
endmodule : asf_monitor

// file: testbench/asf_status_flags_tb.sv
// self-checking bench of the status flag block
`timescale 1ns/100ps
module asf_status_flags_tb;
  import asf_pkg::*;
  logic        mclk, resetn, avs_read, avs_write, avs_waitrequest, irq, result_valid, result_over;
  logic        result_under, cal_mode, cal_done, crc_write_fail, ser_data_read, reg_read_active;
  logic        ser_status_read, cs_n, sclk, dout_rdy_o, dout_rdy_oe, readout_with_status;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, readout_word, r;
  logic [23:0] result_data;
  logic [63:0] reg_image;
  logic [7:0]  b;
  int          err_total = 0;
  int          n_tests = 0;
  asf_status_flags i_asf_status_flags (.*);
  asf_host_model i_asf_host_model (.*);
  always #10 mclk = ~mclk;
  task stop_test;
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // k: 0 result, 1 over, 2 under, 3 calibration, 4 crc fail, 5 serial data read
  task ev(input int k, input logic [23:0] d);
    @(posedge mclk);
    result_data <= d;
    result_valid <= k < 3;
    result_over <= k == 1;
    result_under <= k == 2;
    cal_done <= k == 3;
    crc_write_fail <= k == 4;
    ser_data_read <= k == 5;
    @(posedge mclk);
    {result_valid, cal_done, crc_write_fail, ser_data_read} <= 4'h0;
    repeat (2) @(posedge mclk);
  endtask : ev
  task t_reset;
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
    bus(1, ASF_OFF_STATUS, 32'hff); bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
    bus(0, 5'h14, '0); chk(r, 32'h0);
    bus(0, ASF_OFF_IFMODE, '0); chk(r, 32'h0);
  endtask : t_reset
  task t_irq;
    bus(1, ASF_OFF_IRQ_MASK, 32'h40);
    bus(0, ASF_OFF_IRQ_STAT, '0);
    ev(0, 24'h1); chk(irq, 0);
    ev(1, 24'h1); chk(irq, 1);
    bus(0, ASF_OFF_IRQ_STAT, '0); chk(r, 32'hc0);
    @(posedge mclk); chk(irq, 0);
  endtask : t_irq
  // over, under, clean: error holds until the first clean result
  task t_conv;
    logic [23:0] x;
    for (int i = 0; i < 3; i++) begin
      x = i == 0 ? ASF_CLAMP_HI : i == 1 ? ASF_CLAMP_LO : 24'h5a5a5a;
      ev((i + 1) % 3, 24'h5a5a5a);
      bus(0, ASF_OFF_STATUS, '0); chk(r, {24'h0, 1'b0, i < 2, 6'h0});
      bus(0, ASF_OFF_DATA, '0); chk(r, {8'h00, x});
      chk(readout_word, {8'h00, x}); chk(readout_with_status, 0);
      bus(0, ASF_OFF_STATUS, '0); chk(r, {24'h0, 1'b1, i < 2, 6'h0});
    end
  endtask : t_conv
  task t_cal;
    @(posedge mclk) cal_mode <= 1'b1;
    ev(0, 24'h111111);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
    ev(3, 24'h0);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h00);
    bus(0, ASF_OFF_DATA, '0); chk(r, 32'h5a5a5a);
    @(posedge mclk) cal_mode <= 1'b0;
  endtask : t_cal
  task t_flags;
    ev(4, 24'h0);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'ha0);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
    bus(1, ASF_OFF_IFMODE, 32'h2);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
    @(posedge mclk) reg_image <= reg_image ^ 64'h1;
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h90);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h90);
    bus(1, ASF_OFF_IFMODE, 32'h0);
    bus(0, ASF_OFF_STATUS, '0); chk(r, 32'h80);
  endtask : t_flags
  task t_pin;
    bus(1, ASF_OFF_IFMODE, 32'h1);
    ev(0, 24'hc3c3c3); chk(dout_rdy_o, 0);
    ev(5, 24'h0); chk(dout_rdy_o, 1);
    chk(readout_word[31:8], 24'hc3c3c3); chk(readout_with_status, 1);
    chk(readout_word[7:0], 8'h00);
    i_asf_host_model.rd_status(b); chk(b, 8'h80);
  endtask : t_pin
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    reg_image = 64'h0123456789abcdef;
    {avs_read, avs_write, avs_address, avs_writedata, result_valid, result_data} = '0;
    {result_over, result_under, cal_mode, cal_done, crc_write_fail, ser_data_read} = '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_irq;
    t_conv;
    i_asf_host_model.sel(1);
    t_cal;
    t_flags;
    t_pin;
    i_asf_host_model.sel(0);
    stop_test;
  end
  initial begin
    #100us;
    err_total++;
    stop_test;
  end
endmodule : asf_status_flags_tb
bind asf_status_flags asf_monitor i_asf_monitor (.*);
